// ===== verilog/qdac_pkg.sv
// Package: constants and types shared by both ends of the quad DAC serial control link.
// Assumes a single core clock; frames are 24 bits, MSB first.
package qdac_pkg;
  localparam int unsigned FRAME_BITS     = 24;
  localparam int unsigned CODE_BITS      = 16;
  localparam int unsigned NUM_CH         = 4;
  localparam int unsigned CNT_W          = 5;
  // Flip-flop stages on every pin that enters the core clock domain
  localparam int unsigned SYNC_STAGES    = 2;
  // Field positions in the 24-bit frame
  localparam int unsigned POS_LOAD1      = 21;
  localparam int unsigned POS_LOAD0      = 20;
  localparam int unsigned POS_ZERO       = 19;
  localparam int unsigned POS_SEL_HI     = 18;
  localparam int unsigned POS_SEL_LO     = 17;
  localparam int unsigned POS_PD0        = 16;
  localparam int unsigned POS_PD1        = 15;
  localparam int unsigned POS_PD2        = 14;
  // Reset values
  localparam logic [15:0] CODE_ZERO_SCALE = 16'h0000;
  localparam logic [15:0] CODE_MID_SCALE  = 16'h8000;
  // Host serial clock divider: half period in core cycles
  localparam int unsigned SCLK_HALF_CYC  = 6;
  // Power-down exit time, nanoseconds, at the 5 V supply
  localparam int unsigned PD_EXIT_NS     = 2500;
  localparam int unsigned CORE_PERIOD_NS = 4;
  localparam int unsigned PD_EXIT_CYC    = (PD_EXIT_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  typedef enum logic [1:0] {
    OUT_NORMAL = 2'h0,
    OUT_1K     = 2'h1,
    OUT_100K   = 2'h2,
    OUT_HIZ    = 2'h3
  } out_mode_type;

  typedef struct packed {
    logic [15:0]  code;
    out_mode_type mode;
  } chan_word_type;
endpackage

// ===== verilog/qdac_link_if.sv
// Interface: the three-wire serial link plus the load strobe and enable pin.
// Assumes the host drives every wire; the device only listens.
interface qdac_link_if;
  logic frame_sync_n;
  logic ser_clk;
  logic ser_data;
  logic async_load_strobe;
  logic enable;
  modport host_mp (output frame_sync_n, output ser_clk, output ser_data,
                   output async_load_strobe, output enable);
  modport dev_mp  (input frame_sync_n, input ser_clk, input ser_data,
                   input async_load_strobe, input enable);
endinterface

// ===== verilog/qdac_host.sv
// Host end: shifts out one 24-bit frame per request, MSB first.
// Assumes requests come from logic on core_clk_in; link clock made here by a divider.
module qdac_host
(
  input  wire logic                  core_clk_in,
  input  wire logic                  rstn_in,
  input  wire logic                  send_in,
  input  wire logic [23:0]           frame_in,
  input  wire logic                  strobe_in,
  input  wire logic                  enable_in,
  output logic                       busy_out,
  output logic                       done_out,
  qdac_link_if.host_mp               link
);
  import qdac_pkg::*;
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_HIGH = 3'b010,
    H_LOW  = 3'b100
  } hst_type;
  typedef struct packed {
    hst_type     st;
    logic [23:0] sh;
    logic [4:0]  bits;
    logic [3:0]  div;
    logic        sync_n;
    logic        sclk;
    logic        sdat;
    logic        strobe;
    logic        en;
    logic        busy;
    logic        done;
  } host_state_type;
  host_state_type s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.strobe = strobe_in;
    s_nxt.en = enable_in;
    case (s_r.st)
      H_IDLE: begin
        s_nxt.sync_n = 1'b1;
        s_nxt.sclk = 1'b1;
        if (send_in) begin
          s_nxt.sh = frame_in;
          s_nxt.sync_n = 1'b0;
          s_nxt.sdat = frame_in[23];
          s_nxt.bits = 5'h0;
          s_nxt.div = 4'h0;
          s_nxt.busy = 1'b1;
          s_nxt.st = H_HIGH;
        end
      end
      H_HIGH: begin
        s_nxt.div = s_r.div + 4'h1;
        if (s_r.div == 4'(SCLK_HALF_CYC - 1)) begin
          s_nxt.div = 4'h0;
          s_nxt.sclk = 1'b0;
          s_nxt.st = H_LOW;
        end
      end
      H_LOW: begin
        s_nxt.div = s_r.div + 4'h1;
        if (s_r.div == 4'(SCLK_HALF_CYC - 1)) begin
          s_nxt.div = 4'h0;
          s_nxt.sclk = 1'b1;
          s_nxt.bits = s_r.bits + 5'h1;
          s_nxt.sh = {s_r.sh[22:0], 1'b0};
          s_nxt.sdat = s_r.sh[22];
          if (s_r.bits == 5'(FRAME_BITS - 1)) begin
            s_nxt.sync_n = 1'b1;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.st = H_IDLE;
          end else begin
            s_nxt.st = H_HIGH;
          end
        end
      end
      default: s_nxt.st = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r <= '{st: H_IDLE, sh: 24'h0, bits: 5'h0, div: 4'h0, sync_n: 1'b1, sclk: 1'b1,
               sdat: 1'b0, strobe: 1'b0, en: 1'b0, busy: 1'b0, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.frame_sync_n      = s_r.sync_n;
  assign link.ser_clk           = s_r.sclk;
  assign link.ser_data          = s_r.sdat;
  assign link.async_load_strobe = s_r.strobe;
  assign link.enable            = s_r.en;
  assign busy_out               = s_r.busy;
  assign done_out               = s_r.done;
endmodule

// ===== verilog/qdac_device.sv
// Device end: frame receiver, double-buffered channel registers, load and power-down control.
// Assumes link wires come from outside the core clock domain; all are synchronised here.
// Functional notes
// - Reset level pin picks zero or mid
// - Reference on until change command
// - Update on 24th falling clock edge
// - Strobe held low for sync-only use
// - Strobe rise copies all buffers
// - Host stores buffers before strobe
// - Unchanged buffer keeps present output
// - Enable low for normal operation
// - Enable high ignores serial port
// - Separate channel and reference power-down
// - Mode from bits 16..14
// - 101 1k, 110 100k, 111 high-Z
// - Power-down loaded like data
// - Power-down keeps stored code
// - Allow exit time after power-down
// - Load bits 10 update all channels
// - Load bits 01 update selected channel
// - Bits 18:17 select, bit 19 zero
// - Early sync rise discards frame
// - Load bits 11 broadcast; buffers written only if bit 18 is set, then all buffers copied out
module qdac_device
#(
  parameter int unsigned PD_EXIT_CYCLES = qdac_pkg::PD_EXIT_CYC
)
(
  input  wire logic                                       core_clk_in,
  input  wire logic                                       rstn_in,
  input  wire logic                                       reset_level_select_in,
  qdac_link_if.dev_mp                                     link,
  output logic [qdac_pkg::NUM_CH*qdac_pkg::CODE_BITS-1:0] dac_code_out,
  output logic [qdac_pkg::NUM_CH*2-1:0]                   dac_mode_out,
  output logic [qdac_pkg::NUM_CH-1:0]                     dac_settled_out,
  output logic                                            ref_enabled_out,
  output logic                                            frame_done_out,
  output logic                                            frame_abort_out
);
  import qdac_pkg::*;
  typedef enum logic [2:0] {
    D_INIT  = 3'b001,
    D_IDLE  = 3'b010,
    D_SHIFT = 3'b100
  } dst_type;
  typedef struct packed {
    logic [5:0]                       s1;
    logic [5:0]                       s2;
    logic                             sync_d;
    logic                             sclk_d;
    logic                             strobe_d;
    dst_type                          st;
    logic [23:0]                      sh;
    logic [CNT_W-1:0]                 cnt;
    chan_word_type [NUM_CH-1:0]       buf_w;
    chan_word_type [NUM_CH-1:0]       dac_w;
    logic [NUM_CH-1:0][11:0]          settle;
    logic [NUM_CH-1:0]                settled;
    logic                             ref_en;
    logic                             done;
    logic                             abort;
  } dev_state_type;
  dev_state_type s_r, s_nxt;

  logic sync_n_q, sclk_q, sdat_q, strobe_q, en_q, rst_sel_q;
  assign sync_n_q  = s_r.s2[0];
  assign sclk_q    = s_r.s2[1];
  assign sdat_q    = s_r.s2[2];
  assign strobe_q  = s_r.s2[3];
  assign en_q      = s_r.s2[4];
  assign rst_sel_q = s_r.s2[5];

  function automatic out_mode_type decode_mode(input logic [2:0] pd);
    // Code 100 is undocumented; treated as normal operation
    case (pd)
      3'b101:  decode_mode = OUT_1K;
      3'b110:  decode_mode = OUT_100K;
      3'b111:  decode_mode = OUT_HIZ;
      default: decode_mode = OUT_NORMAL;
    endcase
  endfunction

  // A power-down word keeps the stored code; only the output mode is replaced
  function automatic chan_word_type merge_word(input chan_word_type old_w, input logic pd,
                                               input chan_word_type new_w);
    chan_word_type m;
    m.code = pd ? old_w.code : new_w.code;
    m.mode = new_w.mode;
    return m;
  endfunction

  always_comb begin
    logic          fall;
    logic [23:0]   fr;
    logic [1:0]    sel;
    chan_word_type w;
    logic          pd;
    fall = 1'b0;
    pd = 1'b0;
    fr = 24'h0;
    sel = 2'h0;
    w = '0;
    s_nxt = s_r;
    s_nxt.s1 = {reset_level_select_in, link.enable, link.async_load_strobe,
                link.ser_data, link.ser_clk, link.frame_sync_n};
    s_nxt.s2 = s_r.s1;
    s_nxt.sync_d = sync_n_q;
    s_nxt.sclk_d = sclk_q;
    s_nxt.strobe_d = strobe_q;
    s_nxt.done = 1'b0;
    s_nxt.abort = 1'b0;
    fall = s_r.sclk_d & ~sclk_q;
    case (s_r.st)
      D_INIT: begin
        // Reset level pin is read only after it has crossed both synchroniser stages
        s_nxt.cnt = s_r.cnt + 5'h1;
        if (s_r.cnt == 5'(SYNC_STAGES)) begin
          for (int i = 0; i < NUM_CH; i++) begin
            s_nxt.dac_w[i].code = rst_sel_q ? CODE_MID_SCALE : CODE_ZERO_SCALE;
            s_nxt.buf_w[i].code = s_nxt.dac_w[i].code;
          end
          s_nxt.st = D_IDLE;
        end
      end
      D_IDLE: begin
        // Start on a falling frame sync only; sync still low after a frame must not restart it
        if (!en_q && s_r.sync_d && !sync_n_q) begin
          s_nxt.cnt = '0;
          s_nxt.sh = 24'h0;
          s_nxt.st = D_SHIFT;
        end
      end
      D_SHIFT: begin
        if (sync_n_q || en_q) begin
          s_nxt.sh = 24'h0;
          s_nxt.abort = 1'b1;
          s_nxt.st = D_IDLE;
        end else if (fall) begin
          fr = {s_r.sh[22:0], sdat_q};
          s_nxt.sh = fr;
          s_nxt.cnt = s_r.cnt + 5'h1;
          if (s_r.cnt == 5'(FRAME_BITS - 1)) begin
            sel = fr[POS_SEL_HI:POS_SEL_LO];
            pd = fr[POS_PD0];
            w.code = fr[CODE_BITS-1:0];
            w.mode = decode_mode(fr[POS_PD0:POS_PD2]);
            // Reference path shares the frame with channel path: the load 00 branch still writes buf_w[sel]; command code 00 in D13:D12 aside
            if (fr[POS_PD0] && fr[13:12] == 2'b10 && !fr[POS_LOAD1] && !fr[POS_LOAD0])
              s_nxt.ref_en = 1'b0;
            else if (fr[POS_PD0] && fr[13:12] == 2'b01 && !fr[POS_LOAD1] && !fr[POS_LOAD0])
              s_nxt.ref_en = 1'b1;
            case ({fr[POS_LOAD1], fr[POS_LOAD0]})
              2'b00: s_nxt.buf_w[sel] = merge_word(s_r.buf_w[sel], pd, w);
              2'b01: begin
                s_nxt.buf_w[sel] = merge_word(s_r.buf_w[sel], pd, w);
                s_nxt.dac_w[sel] = merge_word(s_r.dac_w[sel], pd, w);
              end
              2'b10: begin
                s_nxt.buf_w[sel] = merge_word(s_r.buf_w[sel], pd, w);
                s_nxt.dac_w = s_nxt.buf_w;
              end
              default: begin
                if (fr[POS_SEL_HI]) begin
                  for (int i = 0; i < NUM_CH; i++) begin
                    s_nxt.buf_w[i] = merge_word(s_r.buf_w[i], pd, w);
                  end
                end
                s_nxt.dac_w = s_nxt.buf_w;
              end
            endcase
            s_nxt.done = 1'b1;
            s_nxt.st = D_IDLE;
          end
        end
      end
      default: s_nxt.st = D_IDLE;
    endcase
    // Strobe copies all buffers; unchanged buffers reproduce present output
    if (s_r.st != D_INIT && strobe_q && !s_r.strobe_d)
      s_nxt.dac_w = s_nxt.buf_w;
    // Leaving power-down restarts the exit timer; the held code plays no part here
    for (int i = 0; i < NUM_CH; i++) begin
      if (s_nxt.dac_w[i].mode != s_r.dac_w[i].mode && s_r.dac_w[i].mode != OUT_NORMAL) begin
        s_nxt.settle[i] = 12'(PD_EXIT_CYCLES);
        s_nxt.settled[i] = 1'b0;
      end else if (s_r.settle[i] != 12'h0) begin
        s_nxt.settle[i] = s_r.settle[i] - 12'h1;
      end else begin
        s_nxt.settled[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r <= '{s1: 6'h07, s2: 6'h07, sync_d: 1'b1, sclk_d: 1'b1, strobe_d: 1'b0, st: D_INIT,
               sh: 24'h0, cnt: '0, buf_w: '0, dac_w: '0, settle: '0, settled: '1,
               ref_en: 1'b1, done: 1'b0, abort: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_out
      assign dac_code_out[g*CODE_BITS +: CODE_BITS] = s_r.dac_w[g].code;
      assign dac_mode_out[g*2 +: 2]                 = s_r.dac_w[g].mode;
    end
  endgenerate
  assign dac_settled_out = s_r.settled;
  assign ref_enabled_out = s_r.ref_en;
  assign frame_done_out  = s_r.done;
  assign frame_abort_out = s_r.abort;
endmodule

// ===== testbench/qdac_sva.sv
// Checker: link and load-timing properties between the two ends of the quad DAC link.
// Assumes it is instantiated beside the link interface; one core clock domain.
module qdac_sva
(
  input  wire logic                   core_clk_in,
  input  wire logic                   rstn_in,
  input  wire logic                   frame_sync_n,
  input  wire logic                   ser_clk,
  input  wire logic                   ser_data,
  input  wire logic                   async_load_strobe,
  input  wire logic                   enable,
  input  wire logic [qdac_pkg::NUM_CH*qdac_pkg::CODE_BITS-1:0] dac_code_out,
  input  wire logic [qdac_pkg::NUM_CH*2-1:0]    dac_mode_out,
  input  wire logic [qdac_pkg::NUM_CH-1:0]      dac_settled_out,
  input  wire logic                   frame_done_out,
  input  wire logic                   frame_abort_out
);
  import qdac_pkg::*;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  a_idle_clk_still: assert property (frame_sync_n[*3] |-> $stable(ser_clk))
    else $error("serial clock moved outside a frame");
  a_data_at_fall: assert property ($fell(ser_clk) && !frame_sync_n |-> $stable(ser_data))
    else $error("serial data changed at the sampling edge");
  a_enable_ignores: assert property (enable && $past(enable, 4) |-> !frame_done_out)
    else $error("frame accepted while link disabled");
  a_abort_no_change: assert property (frame_abort_out |=> $stable(dac_code_out) && $stable(dac_mode_out))
    else $error("aborted frame changed outputs");
  a_done_after_fall: assert property (frame_done_out |-> !ser_clk && $past(!ser_clk, 3))
    else $error("frame completion not tied to last falling edge");
  a_code_on_frame: assert property ($changed(dac_code_out) && $past(rstn_in, 5) && !async_load_strobe
                                    |-> frame_done_out)
    else $error("output code changed without a frame or strobe");
  a_mode_on_frame: assert property ($changed(dac_mode_out) && $past(rstn_in, 5) && !async_load_strobe
                                    |-> frame_done_out)
    else $error("output mode changed without a frame or strobe");
  // Exit window kept short in simulation through the device parameter
  a_settle_exit: assert property (($past(dac_mode_out[1:0]) != 2'h0) && (dac_mode_out[1:0] == 2'h0)
                                  |-> ##[0:1] !dac_settled_out[0] ##[1:12] dac_settled_out[0])
    else $error("settle flag wrong after leaving power-down");

  c_frame: cover property (frame_done_out);
  c_abort: cover property (frame_abort_out);
  c_strobe: cover property ($rose(async_load_strobe));
endmodule

// ===== testbench/tb_top.sv
// Testbench: host end drives frames over the link into the device end; outputs checked against expected values.
// Assumes the design's 12-cycle serial clock and a short power-down exit window of 8 cycles.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import qdac_pkg::*;

  logic        clk, rstn, sel, send, strobe, en, busy, hdone, ref_on, fdone, fabort;
  logic [23:0] frame;
  logic [63:0] code;
  logic [7:0]  mode;
  logic [3:0]  settled;
  int          error_cnt, num_checks, aborts;

  qdac_link_if link_i ();
  qdac_host qdac_host_i (.core_clk_in(clk), .rstn_in(rstn), .send_in(send), .frame_in(frame),
    .strobe_in(strobe), .enable_in(en), .busy_out(busy), .done_out(hdone), .link(link_i));
  qdac_device #(.PD_EXIT_CYCLES(8)) qdac_device_i (.core_clk_in(clk), .rstn_in(rstn),
    .reset_level_select_in(sel), .link(link_i), .dac_code_out(code), .dac_mode_out(mode),
    .dac_settled_out(settled), .ref_enabled_out(ref_on), .frame_done_out(fdone), .frame_abort_out(fabort));
  qdac_sva qdac_sva_i (.core_clk_in(clk), .rstn_in(rstn), .frame_sync_n(link_i.frame_sync_n),
    .ser_clk(link_i.ser_clk), .ser_data(link_i.ser_data), .async_load_strobe(link_i.async_load_strobe),
    .enable(link_i.enable), .dac_code_out(code), .dac_mode_out(mode), .dac_settled_out(settled),
    .frame_done_out(fdone), .frame_abort_out(fabort));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Abort pulses stand one cycle; counted so scenarios can judge them afterwards
  always @(posedge clk) begin
    if (fabort === 1'b1) aborts++;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Bounded wait on the host completion; the device answers a few cycles earlier
  task automatic send_fr(input logic [1:0] ld, input logic [1:0] ch, input logic pd, input logic [15:0] d);
    int n;
    frame = {2'b00, ld, 1'b0, ch, pd, d};
    send = 1'b1;
    @(posedge clk);
    #1 send = 1'b0;
    chk({63'h0, busy}, 64'h1);
    n = 0;
    while (hdone !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 1000) error_cnt++;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_reset(input logic s);
    rstn = 1'b0;
    sel = s;
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(code, {4{s ? CODE_MID_SCALE : CODE_ZERO_SCALE}});
    chk({56'h0, mode}, 64'h0);
    chk({63'h0, ref_on}, 64'h1);
  endtask

  task automatic t_store_strobe();
    send_fr(2'b00, 2'd0, 1'b0, 16'h1234);
    send_fr(2'b00, 2'd1, 1'b0, 16'h5678);
    chk(code, {4{16'h8000}});
    strobe = 1'b1;
    repeat (10) @(posedge clk);
    #1 strobe = 1'b0;
    chk(code, {16'h8000, 16'h8000, 16'h5678, 16'h1234});
  endtask

  task automatic t_loads();
    send_fr(2'b01, 2'd2, 1'b0, 16'habcd);
    chk(code, {16'h8000, 16'habcd, 16'h5678, 16'h1234});
    send_fr(2'b00, 2'd0, 1'b0, 16'h1111);
    send_fr(2'b10, 2'd3, 1'b0, 16'h2222);
    chk(code, {16'h2222, 16'habcd, 16'h5678, 16'h1111});
    send_fr(2'b11, 2'b10, 1'b0, 16'h3333);
    chk(code, {4{16'h3333}});
    send_fr(2'b00, 2'd1, 1'b0, 16'h4444);
    send_fr(2'b11, 2'b01, 1'b0, 16'h5555);
    chk({48'h0, code[31:16]}, 64'h4444);
  endtask

  task automatic t_powerdown();
    logic [2:0] pd [3] = '{3'b101, 3'b110, 3'b111};
    for (int i = 0; i < 3; i++) begin
      send_fr(2'b01, 2'd0, pd[i][2], {pd[i][1:0], 14'h0});
      chk({62'h0, mode[1:0]}, 64'(i + 1));
      chk({48'h0, code[15:0]}, 64'h3333);
    end
    send_fr(2'b01, 2'd0, 1'b0, 16'hc000);
    chk({56'h0, mode}, 64'h0);
    chk({48'h0, code[15:0]}, 64'hc000);
    chk({60'h0, settled}, 64'he);
    repeat (20) @(posedge clk);
    #1 chk({60'h0, settled}, 64'hf);
    send_fr(2'b11, 2'b10, 1'b1, 16'hc000);
    chk({56'h0, mode}, 64'hff);
    chk(code, {16'h3333, 16'h3333, 16'h4444, 16'hc000});
    send_fr(2'b11, 2'b10, 1'b0, 16'h7777);
    send_fr(2'b00, 2'd0, 1'b1, 16'h2000);
    chk({63'h0, ref_on}, 64'h0);
    chk(code, {4{16'h7777}});
    send_fr(2'b00, 2'd0, 1'b1, 16'h1000);
    chk({63'h0, ref_on}, 64'h1);
  endtask

  task automatic t_enable();
    int a0;
    chk(64'(aborts), 64'h0);
    a0 = aborts;
    en = 1'b1;
    send_fr(2'b01, 2'd1, 1'b0, 16'h0bad);
    chk(code, {4{16'h7777}});
    en = 1'b0;
    fork
      send_fr(2'b01, 2'd1, 1'b0, 16'h0bad);
      begin
        repeat (100) @(posedge clk);
        #1 en = 1'b1;
      end
    join
    chk(code, {4{16'h7777}});
    chk(64'(aborts - a0), 64'h1);
    en = 1'b0;
    send_fr(2'b01, 2'd1, 1'b0, 16'h1357);
    chk(code, {16'h7777, 16'h7777, 16'h1357, 16'h7777});
  endtask

  initial begin
    rstn = 1'b0;
    sel = 1'b1;
    send = 1'b0;
    strobe = 1'b0;
    en = 1'b0;
    frame = 24'h0;
    error_cnt = 0;
    num_checks = 0;
    aborts = 0;
    t_reset(1'b1);
    t_store_strobe();
    t_loads();
    t_powerdown();
    t_enable();
    t_reset(1'b0);
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
